// file: common/jccc_map.vh
// Summary of operation
// - Takeover instruction frees I/O, aborts configuration.
// - Takeover works before configuration or during it.
// - Restart by instruction or restart pin pulse.
// - Chip clear and output enable ignored here.
// - Error status driven low on configuration error.
// - Done released high after successful configuration.
// - Finished device drives chain enable output low.
// - Successful test-port load drives chain output low.
// - Chain output driven low in user mode, or the control value when its user enable is set.
// - Bypass, identify, sample never interrupt configuration.
// - User I/O stays high impedance while configuring.
`ifndef JCCC_MAP_VH
`define JCCC_MAP_VH
// ==========================================================
// Register offsets on the bus.
`define JCCC_ADR_W 8
`define JCCC_REG_CTRL 8'h00
`define JCCC_REG_LEN 8'h04
`define JCCC_REG_STATUS 8'h08
`define JCCC_REG_COUNT 8'h0C
// ==========================================================
// Control fields and reset values.
`define JCCC_CTRL_USER_EN 0
`define JCCC_CTRL_USER_VAL 1
`define JCCC_CTRL_RST 2'h0
`define JCCC_LEN_RST 16'h0010
// ==========================================================
// Status word fields.
`define JCCC_ST_STATE_HI 4
`define JCCC_ST_STATE_LO 0
`define JCCC_ST_ERROR 5
`define JCCC_ST_DONE 6
`define JCCC_ST_TAKE 7
`define JCCC_ST_CHAIN_IN 8
`define JCCC_ST_CLEAR 9
`define JCCC_ST_OE 10
`define JCCC_ST_SCHEME_HI 12
`define JCCC_ST_SCHEME_LO 11
`define JCCC_ST_VALID 13
`define JCCC_ST_FULL 14
// ==========================================================
// Instruction codes of the test port.
`define JCCC_IR_W 4
`define JCCC_IR_BYPASS 4'hF
`define JCCC_IR_IDCODE 4'h6
`define JCCC_IR_SAMPLE 4'h5
`define JCCC_IR_IO_TAKE 4'hD
`define JCCC_IR_PULSE 4'h1
`define JCCC_IR_PROGRAM 4'h2
// ==========================================================
// Timing and synchroniser constants.
`define JCCC_INIT_TCK 9'h12B
`define JCCC_BIT_LAST 3'h7
`define JCCC_SYNC_W 9
`define JCCC_SYNC_RST 9'h103
`endif

// file: rtl/jccc_ctrl.v
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "jccc_map.vh"
module jccc_ctrl (
   // Clock and reset.
   input wire core_clk_in,
   input wire nrst_in,
   // Wishbone slave.
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [`JCCC_ADR_W-1:0] wb_adr_in,
   input wire [3:0] wb_sel_in,
   input wire [31:0] wb_dat_in,
   output reg [31:0] wb_dat_out,
   output reg wb_ack_out,
   // Test port link.
   input wire tck_in,
   input wire tdi_in,
   input wire ir_sel_in,
   // Configuration pins.
   input wire restart_n_in,
   input wire chain_enable_in_n_in,
   input wire chip_clear_n_in,
   input wire chip_output_enable_in,
   input wire [1:0] scheme_select_in,
   output reg error_status_n_out,
   output reg error_status_n_oe_out,
   output reg config_done_out,
   output reg config_done_oe_out,
   output reg chain_enable_out_n_out,
   output reg user_io_hiz_out,
   output reg io_takeover_out,
   // Configuration byte stream.
   output reg [7:0] cfg_data_out,
   output reg cfg_valid_out,
   input wire cfg_ready_in,
   input wire cfg_error_in
);

   // ==========================================================
   // States.
   localparam [4:0] ST_WAIT = 5'h01;
   localparam [4:0] ST_LOAD = 5'h02;
   localparam [4:0] ST_INIT = 5'h04;
   localparam [4:0] ST_USER = 5'h08;
   localparam [4:0] ST_ERROR = 5'h10;

   // ==========================================================
   // Input synchronisers. Order: chip clear, chip output enable, scheme select, tck, tdi, ir_sel,
   // restart_n, chain enable.
   wire [`JCCC_SYNC_W-1:0] raw_in;
   reg [`JCCC_SYNC_W-1:0] sync1_r;
   reg [`JCCC_SYNC_W-1:0] sync2_r;
   reg [`JCCC_SYNC_W-1:0] sync3_r;
   reg [`JCCC_SYNC_W-1:0] filt_r;
   reg [`JCCC_SYNC_W-1:0] filt_q_r;
   assign raw_in = {chip_clear_n_in, chip_output_enable_in, scheme_select_in, tck_in, tdi_in, ir_sel_in,
      restart_n_in, chain_enable_in_n_in};

   // A change is accepted only when the last two stages agree, which masks one-cycle glitches.
   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync1_r <= `JCCC_SYNC_RST;
         sync2_r <= `JCCC_SYNC_RST;
         sync3_r <= `JCCC_SYNC_RST;
         filt_r <= `JCCC_SYNC_RST;
         filt_q_r <= `JCCC_SYNC_RST;
      end else begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         filt_r <= (sync2_r & ~(sync2_r ^ sync3_r)) | (filt_r & (sync2_r ^ sync3_r));
         filt_q_r <= filt_r;
      end
   end

   wire tck_rise = filt_r[4] & ~filt_q_r[4];
   wire tdi_s = filt_r[3];
   wire ir_sel_s = filt_r[2];
   wire ir_update = ~filt_r[2] & filt_q_r[2];
   wire restart_fall = ~filt_r[1] & filt_q_r[1];
   wire ce_n_s = filt_r[0];
   // Chip clear and output enable only feed the status word, never the loading logic.
   wire chip_clear_n_s = filt_r[8];
   wire chip_oe_s = filt_r[7];
   wire [1:0] scheme_s = filt_r[6:5];

   // ==========================================================
   // Registers and state.
   reg [1:0] ctrl_r;
   reg [15:0] len_r;
   reg [15:0] drained_r;
   reg [4:0] state_r;
   reg [4:0] state_nxt;
   reg takeover_r;
   reg [`JCCC_IR_W-1:0] ir_sh_r;
   reg [`JCCC_IR_W-1:0] ir_r;
   reg [7:0] byte_sh_r;
   reg [2:0] bit_cnt_r;
   reg [8:0] init_cnt_r;
   reg [7:0] fifo_tail_r;
   reg fifo_full_r;

   // The pulse instruction restarts on its own update; the pin restarts on its falling edge.
   wire pulse_req = ir_update & (ir_sh_r == `JCCC_IR_PULSE);
   wire take_req = ir_update & (ir_sh_r == `JCCC_IR_IO_TAKE);
   wire restart = restart_fall | pulse_req;
   wire loading = (state_r == ST_LOAD);
   wire data_bit = loading & tck_rise & ~ir_sel_s & (ir_r == `JCCC_IR_PROGRAM);
   wire push = data_bit & (bit_cnt_r == `JCCC_BIT_LAST);
   wire pop = cfg_valid_out & cfg_ready_in;
   wire [7:0] push_byte = {tdi_s, byte_sh_r[7:1]};
   // The host cannot be held off, so a third byte with both entries taken is an overrun.
   wire overrun = push & fifo_full_r & ~pop;

   // ==========================================================
   // Test port instruction and data shifting.
   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ir_sh_r <= `JCCC_IR_BYPASS;
         ir_r <= `JCCC_IR_BYPASS;
         byte_sh_r <= 8'h00;
         bit_cnt_r <= 3'h0;
      end else begin
         if (tck_rise & ir_sel_s) begin
            ir_sh_r <= {tdi_s, ir_sh_r[`JCCC_IR_W-1:1]};
         end
         // Bypass, identify and sample only update the instruction and leave loading alone.
         if (ir_update) begin
            ir_r <= ir_sh_r;
         end
         if (restart | ~loading) begin
            bit_cnt_r <= 3'h0;
         end else if (data_bit) begin
            byte_sh_r <= push_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
         end
      end
   end

   // ==========================================================
   // Two-entry buffer toward the configuration memory.
   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cfg_data_out <= 8'h00;
         cfg_valid_out <= 1'b0;
         fifo_tail_r <= 8'h00;
         fifo_full_r <= 1'b0;
      end else if (restart | take_req) begin
         cfg_valid_out <= 1'b0;
         fifo_full_r <= 1'b0;
      end else if (push & ~pop) begin
         if (!cfg_valid_out) begin
            cfg_data_out <= push_byte;
            cfg_valid_out <= 1'b1;
         end else if (!fifo_full_r) begin
            fifo_tail_r <= push_byte;
            fifo_full_r <= 1'b1;
         end
      end else if (pop & ~push) begin
         if (fifo_full_r) begin
            cfg_data_out <= fifo_tail_r;
            fifo_full_r <= 1'b0;
         end else begin
            cfg_valid_out <= 1'b0;
         end
      end else if (pop & push) begin
         if (fifo_full_r) begin
            cfg_data_out <= fifo_tail_r;
            fifo_tail_r <= push_byte;
         end else begin
            cfg_data_out <= push_byte;
         end
      end
   end

   // ==========================================================
   // Configuration sequencer.
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_WAIT: begin
            if ((ir_r == `JCCC_IR_PROGRAM) & ~ce_n_s & ~takeover_r) begin
               state_nxt = ST_LOAD;
            end
         end
         ST_LOAD: begin
            // A high chain enable, a sink fault or an overrun all spoil the load.
            if (ce_n_s | cfg_error_in | overrun) begin
               state_nxt = ST_ERROR;
            end else if ((drained_r == len_r) & ~cfg_valid_out) begin
               state_nxt = ST_INIT;
            end
         end
         ST_INIT: begin
            if (tck_rise & (init_cnt_r == `JCCC_INIT_TCK - 9'h001)) begin
               state_nxt = ST_USER;
            end
         end
         ST_USER: begin
            state_nxt = ST_USER;
         end
         ST_ERROR: begin
            state_nxt = ST_ERROR;
         end
         default: begin
            state_nxt = ST_WAIT;
         end
      endcase
      if (take_req | restart) begin
         state_nxt = ST_WAIT;
      end
   end

   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_r <= ST_WAIT;
         takeover_r <= 1'b0;
         drained_r <= 16'h0000;
         init_cnt_r <= 9'h000;
      end else begin
         state_r <= state_nxt;
         // Takeover is honoured in any state, so boundary tests can run before or during loading.
         if (restart) begin
            takeover_r <= 1'b0;
         end else if (take_req) begin
            takeover_r <= 1'b1;
         end
         // The count outlives its load so software can still read it once loading has ended.
         if ((state_r != ST_LOAD) & (state_nxt == ST_LOAD)) begin
            drained_r <= 16'h0000;
         end else if (loading & pop) begin
            drained_r <= drained_r + 16'h0001;
         end
         if (state_r != ST_INIT) begin
            init_cnt_r <= 9'h000;
         end else if (tck_rise) begin
            init_cnt_r <= init_cnt_r + 9'h001;
         end
      end
   end

   // ==========================================================
   // Status and chain pins. Chip clear and output enable never reach this logic.
   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         error_status_n_out <= 1'b0;
         error_status_n_oe_out <= 1'b0;
         config_done_out <= 1'b0;
         config_done_oe_out <= 1'b1;
         chain_enable_out_n_out <= 1'b1;
         user_io_hiz_out <= 1'b1;
         io_takeover_out <= 1'b0;
      end else begin
         error_status_n_out <= 1'b0;
         error_status_n_oe_out <= (state_nxt == ST_ERROR);
         config_done_out <= 1'b0;
         config_done_oe_out <= (state_nxt != ST_USER);
         if (state_nxt != ST_USER) begin
            chain_enable_out_n_out <= 1'b1;
         end else if (ctrl_r[`JCCC_CTRL_USER_EN]) begin
            chain_enable_out_n_out <= ctrl_r[`JCCC_CTRL_USER_VAL];
         end else begin
            chain_enable_out_n_out <= 1'b0;
         end
         user_io_hiz_out <= (state_nxt != ST_USER) & ~(takeover_r | take_req);
         io_takeover_out <= ~restart & (takeover_r | take_req);
      end
   end

   // ==========================================================
   // Wishbone slave: one wait state, unmapped reads return zero.
   wire wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   reg [31:0] status_word;

   // Each field sits at its own named position, so the map stays fixed when fields are added.
   always @* begin
      status_word = 32'h0000_0000;
      status_word[`JCCC_ST_STATE_HI:`JCCC_ST_STATE_LO] = state_r;
      status_word[`JCCC_ST_ERROR] = error_status_n_oe_out;
      status_word[`JCCC_ST_DONE] = ~config_done_oe_out;
      status_word[`JCCC_ST_TAKE] = takeover_r;
      status_word[`JCCC_ST_CHAIN_IN] = ce_n_s;
      status_word[`JCCC_ST_CLEAR] = chip_clear_n_s;
      status_word[`JCCC_ST_OE] = chip_oe_s;
      status_word[`JCCC_ST_SCHEME_HI:`JCCC_ST_SCHEME_LO] = scheme_s;
      status_word[`JCCC_ST_VALID] = cfg_valid_out;
      status_word[`JCCC_ST_FULL] = fifo_full_r;
   end

   always @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
         ctrl_r <= `JCCC_CTRL_RST;
         len_r <= `JCCC_LEN_RST;
      end else begin
         wb_ack_out <= wb_req;
         if (wb_req & wb_we_in) begin
            if ((wb_adr_in == `JCCC_REG_CTRL) & wb_sel_in[0]) begin
               ctrl_r <= wb_dat_in[1:0];
            end
            if (wb_adr_in == `JCCC_REG_LEN) begin
               if (wb_sel_in[0]) begin
                  len_r[7:0] <= wb_dat_in[7:0];
               end
               if (wb_sel_in[1]) begin
                  len_r[15:8] <= wb_dat_in[15:8];
               end
            end
         end
         if (wb_req & ~wb_we_in) begin
            case (wb_adr_in)
               `JCCC_REG_CTRL: wb_dat_out <= {30'h0000_0000, ctrl_r};
               `JCCC_REG_LEN: wb_dat_out <= {16'h0000, len_r};
               `JCCC_REG_STATUS: wb_dat_out <= status_word;
               `JCCC_REG_COUNT: wb_dat_out <= {16'h0000, drained_r};
               default: wb_dat_out <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule // jccc_ctrl

// file: tb/jccc_ctrl_asserts.sv
`timescale 1ns/1ps
module jccc_ctrl_asserts (
   // Clock and reset.
   input wire core_clk_in,
   input wire nrst_in,
   // Bus and pins.
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_ack_out,
   input wire restart_n_in,
   input wire error_status_n_out,
   input wire error_status_n_oe_out,
   input wire config_done_out,
   input wire config_done_oe_out,
   input wire chain_enable_out_n_out,
   input wire user_io_hiz_out,
   input wire io_takeover_out,
   // Byte stream.
   input wire [7:0] cfg_data_out,
   input wire cfg_valid_out,
   input wire cfg_ready_in
);
   // ====
   // Checks.
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack held past one cycle");
   a_ack_after_req: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("no ack one cycle after request");
   a_pins_open_drain: assert property (!error_status_n_out && !config_done_out)
      else $error("open drain pin driven high");
   a_done_chain_low: assert property ($fell(config_done_oe_out) |-> !chain_enable_out_n_out)
      else $error("chain output not low at done");
   a_chain_needs_done: assert property ($fell(chain_enable_out_n_out) |-> !config_done_oe_out)
      else $error("chain output low before done");
   a_restart_done: assert property ($fell(restart_n_in) |-> ##[1:8] config_done_oe_out)
      else $error("done not pulled low after restart");
   a_hiz_config: assert property (config_done_oe_out && $past(config_done_oe_out) && !io_takeover_out
      && !$past(io_takeover_out) |-> user_io_hiz_out) else $error("user io driven while configuring");
   a_takeover_io: assert property (io_takeover_out && $past(io_takeover_out) |-> !user_io_hiz_out)
      else $error("takeover left io in high impedance");
   a_error_no_done: assert property (error_status_n_oe_out |-> config_done_oe_out)
      else $error("done released with error");
   a_valid_hold: assert property (cfg_valid_out && !cfg_ready_in |=> cfg_valid_out && $stable(cfg_data_out)
      || error_status_n_oe_out || io_takeover_out) else $error("stream byte lost in stall");
   c_done: cover property ($fell(config_done_oe_out));
   c_error: cover property ($rose(error_status_n_oe_out));
   c_takeover: cover property ($rose(io_takeover_out));
endmodule // jccc_ctrl_asserts
bind jccc_ctrl jccc_ctrl_asserts jccc_ctrl_asserts_inst (.core_clk_in, .nrst_in, .wb_cyc_in, .wb_stb_in,
   .wb_ack_out, .restart_n_in, .error_status_n_out, .error_status_n_oe_out, .config_done_out,
   .config_done_oe_out, .chain_enable_out_n_out, .user_io_hiz_out, .io_takeover_out, .cfg_data_out,
   .cfg_valid_out, .cfg_ready_in);

// file: tb/jccc_host.sv
`timescale 1ns/1ps
module jccc_host (
   // Clock.
   input wire core_clk_in,
   // Test port.
   output logic tck_out,
   output logic tdi_out,
   output logic ir_sel_out
);
   // ====
   // Test clock stands still low between frames; data starts high as a pulled-up pin would.
   initial begin
      tck_out = 1'b0;
      tdi_out = 1'b1;
      ir_sel_out = 1'b0;
   end
   task automatic ticks(input int n);
      repeat (n) begin
         repeat (4) @(posedge core_clk_in);
         tck_out <= 1'b1;
         repeat (4) @(posedge core_clk_in);
         tck_out <= 1'b0;
      end
   endtask
   // Released data shows the inverse of the last bit, so a stale sample cannot pass.
   task automatic shift(input logic [7:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         tdi_out <= v[i];
         ticks(1);
      end
      tdi_out <= ~v[n-1];
   endtask
   task automatic instr(input logic [3:0] code);
      @(posedge core_clk_in);
      ir_sel_out <= 1'b1;
      shift({4'h0, code}, 4);
      repeat (4) @(posedge core_clk_in);
      ir_sel_out <= 1'b0;
      repeat (8) @(posedge core_clk_in);
   endtask
endmodule // jccc_host

// file: tb/tb.sv
`timescale 1ns/1ps
`include "jccc_map.vh"
module tb;
   // ====
   // Pins.
   logic core_clk_in = 1'b0, nrst_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
   logic [7:0] wb_adr_in = 8'h00, cfg_data_out, b;
   logic [3:0] wb_sel_in = 4'h0;
   logic [31:0] wb_dat_in = 32'h0000_0000, wb_dat_out;
   logic wb_ack_out, tck_in, tdi_in, ir_sel_in, cfg_ready_in = 1'b1, cfg_error_in = 1'b0;
   logic restart_n_in = 1'b1, chain_enable_in_n_in = 1'b0;
   logic chip_clear_n_in = 1'b1, chip_output_enable_in = 1'b0;
   logic [1:0] scheme_select_in = 2'h0;
   logic error_status_n_out, error_status_n_oe_out, config_done_out, config_done_oe_out;
   logic chain_enable_out_n_out, user_io_hiz_out, io_takeover_out, cfg_valid_out;
   logic [3:0] codes [3] = '{`JCCC_IR_BYPASS, `JCCC_IR_IDCODE, `JCCC_IR_SAMPLE};
   logic [31:0] bq[$], rq[$];
   int n_errors = 0, comparisons = 0, seed = 45331, rmode = 1;
   always #10 core_clk_in = ~core_clk_in;
   jccc_ctrl jccc_ctrl_inst (.core_clk_in, .nrst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
      .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .tck_in, .tdi_in, .ir_sel_in, .restart_n_in,
      .chain_enable_in_n_in, .chip_clear_n_in, .chip_output_enable_in, .scheme_select_in,
      .error_status_n_out, .error_status_n_oe_out, .config_done_out, .config_done_oe_out,
      .chain_enable_out_n_out, .user_io_hiz_out, .io_takeover_out, .cfg_data_out, .cfg_valid_out,
      .cfg_ready_in, .cfg_error_in);
   jccc_host jccc_host_inst (.core_clk_in, .tck_out(tck_in), .tdi_out(tdi_in), .ir_sel_out(ir_sel_in));
   // ====
   // Checking.
   task automatic summarize;
      if (n_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   always @(posedge core_clk_in) begin
      chip_clear_n_in <= 1'($random(seed));
      chip_output_enable_in <= 1'($random(seed));
      cfg_ready_in <= (rmode == 0) ? 1'($random(seed)) : (rmode == 1);
      if (cfg_valid_out === 1'b1 && cfg_ready_in === 1'b1)
         chk(cfg_data_out, bq.size() ? bq.pop_front() : 32'hxxxx_xxxx);
      if (wb_ack_out === 1'b1 && !wb_we_in)
         chk(wb_dat_out, rq.size() ? rq.pop_front() : 32'hxxxx_xxxx);
   end
   // ====
   // Drivers.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int k;
      if (!we)
         rq.push_back(d);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= we;
      wb_adr_in <= adr;
      wb_sel_in <= 4'hF;
      wb_dat_in <= we ? d : 32'h0000_0000;
      k = 0;
      do begin
         @(posedge core_clk_in);
         k++;
      end while (wb_ack_out !== 1'b1 && k < 50);
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      @(posedge core_clk_in);
      if (k >= 50) begin
         $display("BAD %0t bus ack timeout", $time);
         n_errors++;
         summarize();
      end
   endtask
   task automatic await(input int sel, input logic v);
      int k;
      for (k = 0; k < 400; k++) begin
         @(posedge core_clk_in);
         if ((sel == 0 ? config_done_oe_out : sel == 1 ? error_status_n_oe_out : io_takeover_out) === v)
            break;
      end
      comparisons++;
      if (k == 400) begin
         $display("BAD %0t wait expired", $time);
         n_errors++;
         summarize();
      end
   endtask
   task automatic pulse;
      restart_n_in <= 1'b0;
      repeat (8) @(posedge core_clk_in);
      restart_n_in <= 1'b1;
   endtask
   initial begin
      repeat (20) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      chk({config_done_oe_out, chain_enable_out_n_out, user_io_hiz_out, io_takeover_out,
         error_status_n_oe_out}, 32'h0000_001C);
      wb(0, `JCCC_REG_LEN, 32'h0000_0010);
      wb(0, `JCCC_REG_CTRL, 32'h0000_0000);
      wb(1, 8'h40, 32'h0000_00A5);
      wb(0, 8'h40, 32'h0000_0000);
      wb(1, `JCCC_REG_LEN, 32'h0000_0002);
      rmode <= 0;
      jccc_host_inst.instr(`JCCC_IR_PROGRAM);
      for (int i = 0; i < 2; i++) begin
         b = 8'($random(seed));
         bq.push_back(b);
         jccc_host_inst.shift(b, 8);
         if (i == 0) begin
            foreach (codes[j]) jccc_host_inst.instr(codes[j]);
            jccc_host_inst.instr(`JCCC_IR_PROGRAM);
         end
         rmode <= 1;
      end
      chk({user_io_hiz_out, config_done_oe_out}, 32'h0000_0003);
      jccc_host_inst.ticks(299);
      await(0, 1'b0);
      chk(chain_enable_out_n_out, 32'h0000_0000);
      wb(1, `JCCC_REG_CTRL, 32'h0000_0003);
      chk(chain_enable_out_n_out, 32'h0000_0001);
      wb(1, `JCCC_REG_CTRL, 32'h0000_0000);
      chk(chain_enable_out_n_out, 32'h0000_0000);
      wb(0, `JCCC_REG_COUNT, 32'h0000_0002);
      jccc_host_inst.instr(`JCCC_IR_PULSE);
      await(0, 1'b1);
      jccc_host_inst.instr(`JCCC_IR_PROGRAM);
      bq.push_back(32'h0000_003C);
      jccc_host_inst.shift(8'h3C, 8);
      repeat (8) @(posedge core_clk_in);
      cfg_error_in <= 1'b1;
      await(1, 1'b1);
      cfg_error_in <= 1'b0;
      chk(config_done_oe_out, 32'h0000_0001);
      pulse();
      await(1, 1'b0);
      jccc_host_inst.instr(`JCCC_IR_PROGRAM);
      jccc_host_inst.shift(8'h0F, 4);
      jccc_host_inst.instr(`JCCC_IR_IO_TAKE);
      await(2, 1'b1);
      chk({user_io_hiz_out, config_done_oe_out}, 32'h0000_0001);
      jccc_host_inst.instr(`JCCC_IR_PULSE);
      await(2, 1'b0);
      jccc_host_inst.instr(`JCCC_IR_IO_TAKE);
      await(2, 1'b1);
      pulse();
      await(2, 1'b0);
      rmode <= 2;
      jccc_host_inst.instr(`JCCC_IR_PROGRAM);
      repeat (3) begin
         jccc_host_inst.shift(8'($random(seed)), 8);
         @(posedge core_clk_in);
      end
      await(1, 1'b1);
      summarize();
   end
endmodule // tb
